// ---- exec_pkg.sv ----
// Summary of operation
// - Add-then-branch adds source to destination, writes sum back, byte or word.
// - Nonzero add-then-branch sum jumps to the encoded branch target.
// - Zero add-then-branch sum falls through to the next instruction.
// - Add-then-branch source is a sign-extended immediate from -8 to +7.
// - Branch target spans start address minus 126 to plus 129.
// - Add-then-branch and subtract-then-branch share one operation code.
// - AND stores bitwise AND of source and destination into destination.
// - Byte AND into address register zero-extends source, works at 16 bits.
// - Byte AND from address register uses its low eight bits only.
// - Byte AND with address registers on both sides is refused.
// - AND sets sign flag from result MSB, clears it otherwise.
// - AND sets zero flag when result is zero, clears it otherwise.
// - Short AND form is byte only; word in short form is refused.
// - Short AND with two accumulator byte registers needs them different.
// - Carry-AND ANDs the selected source bit with carry into carry.
// - After carry-AND, carry is one exactly when the AND gave one.
// - Bit clear writes zero to the addressed bit of register, memory or flag.
// - Bit clear with 11-bit static-base offset is accepted in short form only.
`default_nettype none
package exec_pkg;

  // Register map of the small control port
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // Flag field positions and reset value
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_S = 2;
  localparam int FLAG_O = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Status field positions
  localparam int STAT_REFUSED = 0;
  localparam int STAT_TAKEN = 1;

  // Branch displacement counts from start address plus this offset
  localparam logic [15:0] BRANCH_BASE = 16'h0002;
  localparam int BRANCH_BACK_MAX = 126;
  localparam int BRANCH_FWD_MAX = 129;

  // One code for add- and subtract-then-branch
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ADD_BRANCH = 3'b001,
    OP_AND = 3'b010,
    OP_CARRY_AND = 3'b011,
    OP_BIT_CLEAR = 3'b100
  } op_kind_t;

  typedef struct packed {
    logic valid;
    op_kind_t op;
    logic word_size;
    logic sub_variant;
    logic short_form;
    logic [15:0] src;
    logic [15:0] dst;
    logic src_addr;
    logic dst_addr;
    logic src_acc;
    logic dst_acc;
    logic src_acc_high;
    logic dst_acc_high;
    logic [3:0] imm4;
    logic [7:0] disp8;
    logic [15:0] pc;
    logic [2:0] instr_len;
    logic [3:0] bit_pos;
    logic bit_src;
    logic bit_is_flag;
    logic [1:0] flag_sel;
    logic base11_mode;
  } exec_req_t;

  typedef struct packed {
    logic done;
    logic write_dest;
    logic refused;
    logic branch_taken;
    logic [15:0] value;
    logic [15:0] next_pc;
  } exec_res_t;

endpackage : exec_pkg
`default_nettype wire

// ---- exec_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module exec_unit (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire exec_pkg::exec_req_t req,
  output var exec_pkg::exec_res_t res,
  output logic [3:0] flags,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);

  // Registered state
  exec_pkg::exec_res_t res_q, res_d;
  logic [3:0] flags_q, flags_d;
  logic [1:0] status_q, status_d;
  logic [15:0] rdata_q, rdata_d;

  // Request decode
  wire logic go = req.valid;
  wire logic is_ab = go && (req.op == exec_pkg::OP_ADD_BRANCH);
  wire logic is_and = go && (req.op == exec_pkg::OP_AND);
  wire logic is_cand = go && (req.op == exec_pkg::OP_CARRY_AND);
  wire logic is_single_bit_clear_op = go && (req.op == exec_pkg::OP_BIT_CLEAR);

  // Immediate sign extension and subtract variant
  wire logic [15:0] imm_sext = {{12{req.imm4[3]}}, req.imm4};
  wire logic [15:0] imm_neg = 16'h0000 - imm_sext;
  wire logic [15:0] addend = req.sub_variant ? imm_neg : imm_sext;
  wire logic [15:0] sum_w = req.dst + addend;
  wire logic [7:0] sum_b = req.dst[7:0] + addend[7:0];
  wire logic [15:0] ab_value = req.word_size ? sum_w : {req.dst[15:8], sum_b};
  wire logic ab_zero = req.word_size ? (sum_w == 16'h0000) :
    (sum_b == 8'h00);

  // Branch target and fall-through address
  wire logic [15:0] disp_sext = {{8{req.disp8[7]}}, req.disp8};
  wire logic [15:0] target = req.pc + exec_pkg::BRANCH_BASE + disp_sext;
  wire logic [15:0] fall_pc = req.pc + {13'h0000, req.instr_len};
  wire logic ab_jump = is_ab && !ab_zero;
  wire logic [15:0] ab_next = ab_zero ? fall_pc : target;

  // AND operand shaping
  wire logic and_wide = req.word_size || req.dst_addr;
  wire logic [15:0] and_src = req.word_size ? req.src :
    {8'h00, req.src[7:0]};
  wire logic [15:0] and_raw = and_src & req.dst;
  wire logic [15:0] and_value = and_wide ? and_raw :
    {req.dst[15:8], and_raw[7:0]};
  wire logic and_msb = and_wide ? and_raw[15] : and_raw[7];
  wire logic and_zero = and_wide ? (and_raw == 16'h0000) :
    (and_raw[7:0] == 8'h00);

  // Operand combinations that are refused
  wire logic bad_addr = !req.word_size && req.src_addr && req.dst_addr;
  wire logic bad_short_w = req.short_form && req.word_size;
  wire logic bad_acc = req.short_form && req.src_acc && req.dst_acc &&
    (req.src_acc_high == req.dst_acc_high);
  wire logic and_bad = is_and && (bad_addr || bad_short_w || bad_acc);
  wire logic single_bit_clear_op_bad = is_single_bit_clear_op && req.base11_mode && !req.short_form;
  wire logic refuse = and_bad || single_bit_clear_op_bad;

  // Bit clear mask
  wire logic [15:0] bit_mask = 16'h0001 << req.bit_pos;
  wire logic [15:0] single_bit_clear_op_value = req.dst & ~bit_mask;
  wire logic single_bit_clear_op_data = is_single_bit_clear_op && !single_bit_clear_op_bad && !req.bit_is_flag;
  wire logic single_bit_clear_op_flag = is_single_bit_clear_op && !single_bit_clear_op_bad && req.bit_is_flag;

  // Carry-AND result
  wire logic cand_c = req.bit_src & flags_q[exec_pkg::FLAG_C];

  // Register port decode
  wire logic wr_flags = reg_wr && (reg_addr == exec_pkg::OFF_FLAGS);
  wire logic wr_status = reg_wr && (reg_addr == exec_pkg::OFF_STATUS);
  wire logic hw_flags = go && !refuse &&
    (is_and || is_cand || single_bit_clear_op_flag);

  // Result selection
  always_comb begin
    res_d = '0;
    res_d.done = go;
    res_d.refused = refuse;
    res_d.next_pc = fall_pc;
    res_d.value = req.dst;
    if (is_ab) begin
      res_d.write_dest = 1'b1;
      res_d.value = ab_value;
      res_d.branch_taken = ab_jump;
      res_d.next_pc = ab_next;
    end else if (is_and && !and_bad) begin
      res_d.write_dest = 1'b1;
      res_d.value = and_value;
    end else if (single_bit_clear_op_data) begin
      res_d.write_dest = 1'b1;
      res_d.value = single_bit_clear_op_value;
    end
  end

  // Flag update; the executing instruction wins over a software write
  always_comb begin
    flags_d = flags_q;
    if (hw_flags) begin
      if (is_and) begin
        flags_d[exec_pkg::FLAG_S] = and_msb;
        flags_d[exec_pkg::FLAG_Z] = and_zero;
      end else if (is_cand) begin
        flags_d[exec_pkg::FLAG_C] = cand_c;
      end else begin
        flags_d[req.flag_sel] = 1'b0;
      end
    end else if (wr_flags) begin
      flags_d = reg_wdata[3:0];
    end
  end

  // Status: sticky refusal, cleared by writing one; a new refusal wins
  always_comb begin
    status_d = status_q;
    if (wr_status && reg_wdata[exec_pkg::STAT_REFUSED]) begin
      status_d[exec_pkg::STAT_REFUSED] = 1'b0;
    end
    if (refuse) begin
      status_d[exec_pkg::STAT_REFUSED] = 1'b1;
    end
    if (is_ab) begin
      status_d[exec_pkg::STAT_TAKEN] = ab_jump;
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        exec_pkg::OFF_FLAGS: rdata_d = {12'h000, flags_q};
        exec_pkg::OFF_RESULT: rdata_d = res_q.value;
        exec_pkg::OFF_STATUS: rdata_d = {14'h0000, status_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      res_q <= '0;
      flags_q <= exec_pkg::FLAGS_RESET;
      status_q <= 2'h0;
      rdata_q <= 16'h0000;
    end else if (ce) begin
      res_q <= res_d;
      flags_q <= flags_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
    end
  end

  assign res = res_q;
  assign flags = flags_q;
  assign reg_rdata = rdata_q;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  wire logic step = ce && !reset;
  // Target offset from the start address, modulo the address space
  wire logic [15:0] tgt_diff = target - req.pc;

  // Add-then-branch, AND, carry-AND and bit clear results and flags
  a_branch_taken: assert property (
    step && is_ab && !ab_zero |=> res_q.branch_taken && res_q.next_pc ==
      $past(target))
    else $error("nonzero sum did not branch to target");

  a_fall_through: assert property (
    step && is_ab && ab_zero |=> !res_q.branch_taken &&
      res_q.next_pc == $past(fall_pc))
    else $error("zero sum did not fall through");

  a_sum_written: assert property (
    step && is_ab && req.word_size |=> res_q.write_dest &&
      res_q.value == $past(req.dst) + $past(addend))
    else $error("word sum not written back");

  a_imm_range: assert property (
    step && is_ab && !req.sub_variant && req.word_size |=>
      res_q.value == $past(req.dst) + {{12{$past(req.imm4[3])}},
      $past(req.imm4)})
    else $error("immediate not sign-extended before add");

  a_target_window: assert property (
    step && is_ab |-> $signed(tgt_diff) >= -16'sd126 &&
      $signed(tgt_diff) <= 16'sd129)
    else $error("branch target outside window");

  a_sub_shares_code: assert property (
    step && is_ab && req.sub_variant && req.word_size |=>
      res_q.value == $past(req.dst) - {{12{$past(req.imm4[3])}},
      $past(req.imm4)})
    else $error("subtract variant result wrong");

  a_byte_sum: assert property (
    step && is_ab && !req.word_size |=> res_q.write_dest &&
      res_q.value[15:8] == $past(req.dst[15:8]))
    else $error("byte sum disturbed the high byte");

  a_and_result: assert property (
    step && is_and && !and_bad && req.word_size |=>
      res_q.value == ($past(req.src) & $past(req.dst)))
    else $error("word AND result wrong");

  a_and_zext: assert property (
    step && is_and && !and_bad && !req.word_size && req.dst_addr |=>
      res_q.value[15:8] == 8'h00)
    else $error("byte AND into address register not zero-extended");

  a_and_low_src: assert property (
    step && is_and && !and_bad && !req.word_size && req.src_addr |=>
      res_q.value[7:0] == ($past(req.src[7:0]) & $past(req.dst[7:0])))
    else $error("byte AND from address register used wrong bits");

  a_refuse_addr: assert property (
    step && is_and && bad_addr |=> res_q.refused && !res_q.write_dest)
    else $error("two address registers in byte AND not refused");

  a_sign_flag: assert property (
    step && is_and && !and_bad |=> flags_q[exec_pkg::FLAG_S] ==
      (($past(req.word_size) || $past(req.dst_addr)) ? res_q.value[15] :
      res_q.value[7]))
    else $error("sign flag wrong after AND");

  a_zero_flag: assert property (
    step && is_and && !and_bad |=> flags_q[exec_pkg::FLAG_Z] ==
      (res_q.value == 16'h0000 || (!$past(and_wide) &&
      res_q.value[7:0] == 8'h00)))
    else $error("zero flag wrong after AND");

  a_short_byte: assert property (
    step && is_and && req.short_form && req.word_size |=>
      res_q.refused && !res_q.write_dest)
    else $error("word AND in short form not refused");

  a_acc_distinct: assert property (
    step && is_and && bad_acc && !wr_flags |=> res_q.refused &&
      flags_q == $past(flags_q))
    else $error("same accumulator byte twice not refused");

  a_carry_and: assert property (
    step && is_cand |=> flags_q[exec_pkg::FLAG_C] ==
      ($past(req.bit_src) && $past(flags_q[exec_pkg::FLAG_C])))
    else $error("carry after carry-AND wrong");

  a_bit_cleared: assert property (
    step && single_bit_clear_op_data |=> res_q.value[$past(req.bit_pos)] == 1'b0 &&
      (res_q.value | $past(bit_mask)) == ($past(req.dst) | $past(bit_mask)))
    else $error("bit clear touched wrong bits");

  a_base11_short: assert property (
    step && is_single_bit_clear_op && req.base11_mode && !req.short_form |=>
      res_q.refused && !res_q.write_dest)
    else $error("eleven-bit base mode outside short form accepted");

  a_flags_kept: assert property (
    step && (is_ab || (is_and && !and_bad)) && !wr_flags |=>
      flags_q[exec_pkg::FLAG_C] == $past(flags_q[exec_pkg::FLAG_C]) &&
      flags_q[exec_pkg::FLAG_O] == $past(flags_q[exec_pkg::FLAG_O]))
    else $error("untouched flags changed");

  // Flags each instruction must leave alone
  a_ab_no_flags: assert property (
    step && is_ab && !wr_flags |=> flags_q == $past(flags_q))
    else $error("add-then-branch changed a flag");

  a_cand_only_carry: assert property (
    step && is_cand |=> flags_q[3:1] == $past(flags_q[3:1]))
    else $error("carry-AND changed a flag other than carry");

  a_single_bit_clear_op_flags_kept: assert property (
    step && single_bit_clear_op_data && !wr_flags |=> flags_q == $past(flags_q))
    else $error("bit clear of data changed a flag");

  // Bit clear aimed at a flag, carry-AND side effects, and byte AND high byte
  a_flag_bit_cleared: assert property (
    step && single_bit_clear_op_flag |=> !flags_q[$past(req.flag_sel)] &&
      !res_q.write_dest)
    else $error("flag bit not cleared");

  a_cand_no_dest: assert property (
    step && is_cand |=> res_q.done && !res_q.write_dest && !res_q.refused)
    else $error("carry-AND wrote a destination");

  a_and_keeps_high: assert property (
    step && is_and && !and_bad && !req.word_size && !req.dst_addr |=>
      res_q.value[15:8] == $past(req.dst[15:8]))
    else $error("byte AND disturbed the high byte");

  // Refusals leave no trace but the refused result bit and the sticky status bit
  a_refused_quiet: assert property (
    step && refuse |=> res_q.refused && !res_q.write_dest &&
      !res_q.branch_taken)
    else $error("refused instruction had an effect");

  a_refused_sticky: assert property (
    step && refuse |=> status_q[exec_pkg::STAT_REFUSED])
    else $error("refusal not recorded in status");

  a_refused_pc: assert property (
    step && refuse |=> res_q.next_pc == $past(req.pc) +
      {13'h0000, $past(req.instr_len)})
    else $error("refused instruction did not fall through");

  a_status_taken: assert property (
    step && is_ab |=> status_q[exec_pkg::STAT_TAKEN] == res_q.branch_taken)
    else $error("status branch bit disagrees with result");

  // Port timing: one-cycle done pulse and read data
  a_done_pulse: assert property (
    step && !req.valid |=> !res_q.done)
    else $error("done without a request");

  a_rdata_idle: assert property (
    step && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

  // Clock enable low holds every register
  a_freeze: assert property (
    !ce |=> $stable(res_q) && $stable(flags_q))
    else $error("state moved with clock enable low");

  c_branch: cover property (step && ab_jump);
  c_fall: cover property (step && is_ab && ab_zero);
  c_and_refused: cover property (step && and_bad);
  c_flag_clear: cover property (step && single_bit_clear_op_flag);
  c_carry_and: cover property (step && is_cand && flags_q[exec_pkg::FLAG_C]);

endmodule : exec_unit
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    exec_pkg::op_kind_t op;
    logic word;
    logic sub;
    logic [3:0] bitv;
    logic [15:0] src;
    logic [15:0] dst;
    logic [3:0] imm4;
    logic [7:0] disp8;
    logic [3:0] fin;
    logic [15:0] ev;
    logic et;
    logic [3:0] ef;
  } row_t;
  localparam exec_pkg::op_kind_t ab = exec_pkg::OP_ADD_BRANCH;
  localparam exec_pkg::op_kind_t an = exec_pkg::OP_AND;
  localparam exec_pkg::op_kind_t ca = exec_pkg::OP_CARRY_AND;
  localparam exec_pkg::op_kind_t bc = exec_pkg::OP_BIT_CLEAR;
  logic ref_clk;
  logic reset;
  logic ce;
  exec_pkg::exec_req_t req;
  exec_pkg::exec_res_t res;
  logic [3:0] flags;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  row_t rows[13];
  exec_pkg::exec_req_t r;
  logic [15:0] rd;
  logic [15:0] npc;
  int num_errors;
  int cmp_count;

  exec_unit dut_u (.ref_clk(ref_clk), .reset(reset), .ce(ce), .req(req),
    .res(res), .flags(flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end

  task automatic conclude;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // One instruction, result sampled in its answer cycle
  task automatic exec(input exec_pkg::exec_req_t q);
    @(posedge ref_clk);
    req <= q;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    #1;
  endtask : exec

  function automatic exec_pkg::exec_req_t base();
    exec_pkg::exec_req_t b;
    b = '0;
    b.valid = 1'b1;
    b.pc = 16'h0100;
    b.instr_len = 3'd3;
    return b;
  endfunction : base

  // Main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    req = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    rows[0] = '{ab, 1'b1, 1'b0, 4'h0, 16'h0000, 16'h0005, 4'hf, 8'h80,
      4'h5, 16'h0004, 1'b1, 4'h5};
    rows[1] = '{ab, 1'b1, 1'b0, 4'h0, 16'h0000, 16'h0001, 4'hf, 8'h7f,
      4'ha, 16'h0000, 1'b0, 4'ha};
    rows[2] = '{ab, 1'b0, 1'b0, 4'h0, 16'h0000, 16'h12ff, 4'h1, 8'h80,
      4'hf, 16'h1200, 1'b0, 4'hf};
    rows[3] = '{ab, 1'b0, 1'b0, 4'h0, 16'h0000, 16'h0010, 4'h7, 8'h7f,
      4'h0, 16'h0017, 1'b1, 4'h0};
    rows[4] = '{ab, 1'b1, 1'b1, 4'h0, 16'h0000, 16'h0008, 4'h8, 8'h80,
      4'h3, 16'h0010, 1'b1, 4'h3};
    rows[5] = '{an, 1'b1, 1'b0, 4'h0, 16'hf0f0, 16'hff00, 4'h0, 8'h00,
      4'h9, 16'hf000, 1'b0, 4'hd};
    rows[6] = '{an, 1'b1, 1'b0, 4'h0, 16'h00ff, 16'hff00, 4'h0, 8'h00,
      4'h4, 16'h0000, 1'b0, 4'h2};
    rows[7] = '{an, 1'b0, 1'b0, 4'h0, 16'h0080, 16'haaff, 4'h0, 8'h00,
      4'h0, 16'haa80, 1'b0, 4'h4};
    rows[8] = '{an, 1'b0, 1'b0, 4'h0, 16'hff0f, 16'h12f0, 4'h0, 8'h00,
      4'h4, 16'h1200, 1'b0, 4'h2};
    rows[9] = '{ca, 1'b0, 1'b0, 4'h1, 16'h0000, 16'h0000, 4'h0, 8'h00,
      4'h1, 16'h0000, 1'b0, 4'h1};
    rows[10] = '{ca, 1'b0, 1'b0, 4'h0, 16'h0000, 16'h0000, 4'h0, 8'h00,
      4'hf, 16'h0000, 1'b0, 4'he};
    rows[11] = '{bc, 1'b1, 1'b0, 4'hf, 16'h0000, 16'h8000, 4'h0, 8'h00,
      4'ha, 16'h0000, 1'b0, 4'ha};
    rows[12] = '{bc, 1'b1, 1'b0, 4'h3, 16'h0000, 16'hffff, 4'h0, 8'h00,
      4'h5, 16'hfff7, 1'b0, 4'h5};
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    check("reset_done", 16'h0000, {15'h0000, res.done});
    check("reset_flags", 16'h0000, {12'h000, flags});
    reg_read(exec_pkg::OFF_STATUS, rd);
    check("reset_status", 16'h0000, rd);
    // Table of ordinary instructions
    foreach (rows[i]) begin
      reg_write(exec_pkg::OFF_FLAGS, {12'h000, rows[i].fin});
      r = base();
      r.op = rows[i].op;
      r.word_size = rows[i].word;
      r.sub_variant = rows[i].sub;
      r.src = rows[i].src;
      r.dst = rows[i].dst;
      r.imm4 = rows[i].imm4;
      r.disp8 = rows[i].disp8;
      r.bit_pos = rows[i].bitv;
      r.bit_src = rows[i].bitv[0];
      exec(r);
      npc = 16'h0103;
      if (rows[i].et) npc = 16'h0102 + {{8{r.disp8[7]}}, r.disp8};
      check("done", 16'h0001, {15'h0000, res.done});
      if (r.op != ca) check("value", rows[i].ev, res.value);
      check("taken", {15'h0000, rows[i].et}, {15'h0000, res.branch_taken});
      check("next_pc", npc, res.next_pc);
      check("flags", {12'h000, rows[i].ef}, {12'h000, flags});
    end
    // Result register read in the cycle right after the instruction
    @(posedge ref_clk);
    req <= r;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    reg_addr <= exec_pkg::OFF_RESULT;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check("result_reg", 16'hfff7, reg_rdata);
    reg_read(exec_pkg::OFF_STATUS, rd);
    check("status_taken", 16'h0002, rd);
    // Byte AND widened into an address register, then from one
    r = base();
    r.op = an;
    r.dst_addr = 1'b1;
    r.src = 16'h1280;
    r.dst = 16'hffff;
    exec(r);
    check("wide_and", 16'h0080, res.value);
    check("wide_flags", 16'h0001, {12'h000, flags});
    r.dst_addr = 1'b0;
    r.src_addr = 1'b1;
    r.src = 16'hab55;
    r.dst = 16'h12ff;
    exec(r);
    check("addr_src_and", 16'h1255, res.value);
    // Refused operand forms beside accepted neighbours
    for (int i = 0; i < 6; i++) begin
      reg_write(exec_pkg::OFF_FLAGS, 16'h0002);
      r = base();
      r.op = an;
      r.src = 16'h00f0;
      r.dst = 16'hffff;
      case (i)
        0: {r.src_addr, r.dst_addr} = 2'b11;
        1: {r.word_size, r.short_form} = 2'b11;
        2, 4: {r.short_form, r.src_acc, r.dst_acc, r.src_acc_high} =
          {3'b111, i == 4};
        default: begin
          r.op = bc;
          r.base11_mode = 1'b1;
          r.short_form = (i == 5);
        end
      endcase
      exec(r);
      check("refused", {15'h0000, i < 4}, {15'h0000, res.refused});
      check("write_dest", {15'h0000, i > 3}, {15'h0000, res.write_dest});
      check("next_pc", 16'h0103, res.next_pc);
      check("flags", (i == 4) ? 16'h0004 : 16'h0002, {12'h000, flags});
      reg_read(exec_pkg::OFF_STATUS, rd);
      check("status_refused", {15'h0000, i < 4}, {15'h0000, rd[0]});
      reg_write(exec_pkg::OFF_STATUS, 16'h0001);
    end
    // Clearing one flag bit
    reg_write(exec_pkg::OFF_FLAGS, 16'h000f);
    r = base();
    r.op = bc;
    r.bit_is_flag = 1'b1;
    r.flag_sel = 2'd2;
    exec(r);
    check("flag_clear", 16'h000b, {12'h000, flags});
    check("flag_no_dest", 16'h0000, {15'h0000, res.write_dest});
    // Flags write colliding with a word AND
    r = base();
    r.op = an;
    r.word_size = 1'b1;
    r.src = 16'h8000;
    r.dst = 16'h8001;
    @(posedge ref_clk);
    reg_addr <= exec_pkg::OFF_FLAGS;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'b1;
    req <= r;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    req.valid <= 1'b0;
    #1;
    check("collide_flags", 16'h000d, {12'h000, flags});
    // Clock enable low: request and flags write must both be held off
    r = base();
    r.op = an;
    r.word_size = 1'b1;
    @(posedge ref_clk);
    ce <= 1'b0;
    req <= r;
    reg_addr <= exec_pkg::OFF_FLAGS;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    ce <= 1'b1;
    reg_wr <= 1'b0;
    req.valid <= 1'b0;
    #1;
    check("frozen_done", 16'h0000, {15'h0000, res.done});
    check("frozen_flags", 16'h000d, {12'h000, flags});
    conclude();
  end
endmodule : tb
`default_nettype wire
